// file: pcpc_pkg.sv
// constants, register map and timing for the parallel channel protection block
// assumes a 40 MHz system clock and a zero-wait AHB-Lite slave
// Behaviour
// - two pair bits: channels 0&3, 1&2
// - paired channels trip and restart together
// - paired mode uses reduced paired trip level
// - either low select gives paired low level
// - shared restart counts; both latch at limit
// - either slow select slows both paired channels
// - pairing disables small-load drop limitation
// - slow select halves slew both directions
// - drop limit only on diagnosed channel
// - reverse flow keeps channel state unchanged unless the paired partner trips
// - switch-on accepted during reverse flow
// - no own protection acts during reverse flow; a paired partner trip still switches off
package pcpc_pkg;
  localparam int NCH = 4;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESTART_TIME_NS = 10000;
  localparam int RESTART_CYC = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 9;
  localparam int CNT_W = 4;
  localparam logic [7:0] A_PAIR = 8'h00;
  localparam logic [7:0] A_TRIP = 8'h04;
  localparam logic [7:0] A_SLEW = 8'h08;
  localparam logic [7:0] A_DIAG = 8'h0C;
  localparam logic [7:0] A_OUT = 8'h10;
  localparam logic [7:0] A_CLR_CNT = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_CNT = 8'h1C;
  localparam logic [7:0] A_IRQ_STAT = 8'h20;
  localparam logic [7:0] A_IRQ_CLR = 8'h24;
  localparam logic [7:0] A_IRQ_EN = 8'h28;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {
    TRIP_NORM = 2'h0,
    TRIP_LOW = 2'h1,
    TRIP_PAIR = 2'h2,
    TRIP_PAIR_LOW = 2'h3
  } pcpc_trip_e;
  function automatic int partner(input int i);
    return NCH - 1 - i;
  endfunction : partner
  function automatic int pair_of(input int i);
    return (i == 0 || i == NCH - 1) ? 0 : 1;
  endfunction : pair_of
endpackage : pcpc_pkg

// file: pcpc_ctrl.sv
// protection, pairing and slew control for four high-side channels
// assumes pin-level comparator inputs from the analog side, asynchronous to CLK_SYS
`timescale 1ns/1ps
module pcpc_ctrl #(
  parameter logic [3:0] RESTART_LIMIT = 4'h8
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [3:0] OVL_NORM,
  input wire logic [3:0] OVL_LOW,
  input wire logic [3:0] OVL_PAIR,
  input wire logic [3:0] OVL_PAIR_LOW,
  input wire logic [3:0] OVER_TEMP,
  input wire logic [3:0] REV_FLOW,
  input wire logic [3:0] SLC_DROP,
  output logic [3:0] GATE_ON,
  output logic [3:0] SLOW_SLEW,
  output logic [3:0] SLC_ENGAGE,
  output logic [7:0] TRIP_LEVEL,
  output logic IRQ
);
  localparam int NCH = pcpc_pkg::NCH;
  localparam int CW = pcpc_pkg::CNT_W;
  localparam int TW = pcpc_pkg::TMR_W;
  localparam logic [TW-1:0] RST_TMR = TW'(pcpc_pkg::RESTART_CYC);

  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  // pins pass two flops; the first stage is read by the second only
  logic [27:0] pin_s1, pin_s2;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 28'h0;
      pin_s2 <= 28'h0;
    end else if (CE) begin
      pin_s1 <= {SLC_DROP, REV_FLOW, OVER_TEMP, OVL_PAIR_LOW, OVL_PAIR, OVL_LOW, OVL_NORM};
      pin_s2 <= pin_s1;
    end
  end
  wire [3:0] ovl_norm = pin_s2[3:0];
  wire [3:0] ovl_low = pin_s2[7:4];
  wire [3:0] ovl_pair = pin_s2[11:8];
  wire [3:0] ovl_pair_low = pin_s2[15:12];
  wire [3:0] over_temp = pin_s2[19:16];
  wire [3:0] rev = pin_s2[23:20];
  wire [3:0] slc_drop = pin_s2[27:24];

  // register file
  logic [1:0] pair_join_enable;
  logic [3:0] low_trip_select, slow_slew_select, cmd;
  logic [2:0] diag_channel_select;
  logic [7:0] irq_stat, irq_en;
  logic [7:0] d_addr;
  logic d_write;
  wire a_take = HSEL && HREADY && (HTRANS == pcpc_pkg::HTRANS_NONSEQ || HTRANS == pcpc_pkg::HTRANS_SEQ);
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      d_addr <= 8'h00;
      d_write <= 1'b0;
    end else if (CE && HREADY) begin
      d_addr <= a_take ? HADDR[7:0] : 8'h00;
      d_write <= a_take && HWRITE;
    end
  end
  wire wr_pair = d_write && d_addr == pcpc_pkg::A_PAIR;
  wire wr_trip = d_write && d_addr == pcpc_pkg::A_TRIP;
  wire wr_slew = d_write && d_addr == pcpc_pkg::A_SLEW;
  wire wr_diag = d_write && d_addr == pcpc_pkg::A_DIAG;
  wire wr_out = d_write && d_addr == pcpc_pkg::A_OUT;
  wire wr_clr = d_write && d_addr == pcpc_pkg::A_CLR_CNT;
  wire wr_iclr = d_write && d_addr == pcpc_pkg::A_IRQ_CLR;
  wire wr_ien = d_write && d_addr == pcpc_pkg::A_IRQ_EN;
  wire [3:0] clr_cnt = wr_clr ? HWDATA[3:0] : 4'h0;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pair_join_enable <= 2'h0;
      low_trip_select <= 4'h0;
      slow_slew_select <= 4'h0;
      diag_channel_select <= 3'h0;
      cmd <= 4'h0;
      irq_en <= 8'h00;
    end else if (CE) begin
      if (wr_pair) pair_join_enable <= HWDATA[1:0];
      if (wr_trip) low_trip_select <= HWDATA[3:0];
      if (wr_slew) slow_slew_select <= HWDATA[3:0];
      if (wr_diag) diag_channel_select <= HWDATA[2:0];
      if (wr_out) cmd <= HWDATA[3:0];
      if (wr_ien) irq_en <= HWDATA[7:0];
    end
  end

  // per-channel protection
  logic [3:0] paired, own_fault, trip_ev, upd, wait_rs, latched, done, release_rs;
  logic [3:0] eff_low, eff_slow, slc_next;
  logic [TW-1:0] tmr [NCH];
  logic [CW-1:0] rcnt [NCH];
  logic [CW-1:0] next_rcnt [NCH];
  pcpc_pkg::pcpc_trip_e lvl [NCH];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int P = pcpc_pkg::partner(i);
    assign paired[i] = pair_join_enable[pcpc_pkg::pair_of(i)];
    assign eff_low[i] = low_trip_select[i] | (paired[i] & low_trip_select[P]);
    assign lvl[i] = paired[i] ? (eff_low[i] ? pcpc_pkg::TRIP_PAIR_LOW : pcpc_pkg::TRIP_PAIR)
                  : (low_trip_select[i] ? pcpc_pkg::TRIP_LOW : pcpc_pkg::TRIP_NORM);
    wire ovl = (lvl[i] == pcpc_pkg::TRIP_PAIR_LOW) ? ovl_pair_low[i]
             : (lvl[i] == pcpc_pkg::TRIP_PAIR) ? ovl_pair[i]
             : (lvl[i] == pcpc_pkg::TRIP_LOW) ? ovl_low[i] : ovl_norm[i];
    // reverse flow masks the channel's own overload and over-temperature paths; partner trips still act
    assign own_fault[i] = (ovl | over_temp[i]) & ~rev[i];
    assign trip_ev[i] = own_fault[i] & GATE_ON[i];
    assign upd[i] = trip_ev[i] | (paired[i] & trip_ev[P]);
    wire [CW-1:0] base = (paired[i] && rcnt[P] > rcnt[i]) ? rcnt[P] : rcnt[i];
    assign next_rcnt[i] = (base == {CW{1'b1}}) ? base : base + CW'(1);
    assign done[i] = wait_rs[i] && tmr[i] == '0;
    assign release_rs[i] = done[i] && (!paired[i] || !wait_rs[P] || done[P]);
    wire hit = next_rcnt[i] >= RESTART_LIMIT;
    wire hit_p = paired[i] && upd[i] && next_rcnt[P] >= RESTART_LIMIT;
    assign eff_slow[i] = slow_slew_select[i] | (paired[i] & slow_slew_select[P]);
    assign slc_next[i] = !paired[i] && GATE_ON[i] && diag_channel_select == 3'(i)
                       && slc_drop[i];
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
        wait_rs[i] <= 1'b0;
        tmr[i] <= '0;
        rcnt[i] <= '0;
        latched[i] <= 1'b0;
      end else if (CE) begin
        if (clr_cnt[i]) begin
          rcnt[i] <= '0;
          latched[i] <= 1'b0;
        end else if (upd[i]) begin
          rcnt[i] <= next_rcnt[i];
          latched[i] <= latched[i] | hit | hit_p;
        end
        if (upd[i]) begin
          wait_rs[i] <= 1'b1;
          tmr[i] <= RST_TMR;
        end else if (release_rs[i]) begin
          wait_rs[i] <= 1'b0;
        end else if (wait_rs[i] && tmr[i] != '0) begin
          tmr[i] <= tmr[i] - TW'(1);
        end
      end
    end
  end

  // switch-on is taken regardless of reverse flow
  wire [3:0] next_gate = cmd & ~wait_rs & ~latched & ~upd;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      GATE_ON <= 4'h0;
      SLOW_SLEW <= 4'h0;
      SLC_ENGAGE <= 4'h0;
      TRIP_LEVEL <= 8'h00;
    end else if (CE) begin
      GATE_ON <= next_gate;
      SLOW_SLEW <= eff_slow;
      SLC_ENGAGE <= slc_next;
      TRIP_LEVEL <= {lvl[3], lvl[2], lvl[1], lvl[0]};
    end
  end

  // interrupts: trips in [3:0], latch-offs in [7:4]; set beats clear
  logic [3:0] latched_d;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 8'h00;
      latched_d <= 4'h0;
    end else if (CE) begin
      latched_d <= latched;
      irq_stat <= (irq_stat & ~(wr_iclr ? HWDATA[7:0] : 8'h00))
                | {latched & ~latched_d, trip_ev};
    end
  end
  assign IRQ = |(irq_stat & irq_en);

  // read mux, zero wait states, always OKAY
  // the word is picked in the address phase so that it stands through the data phase;
  // limitation: a read right behind a write to the same register returns the old word
  wire [7:0] rd_addr = HADDR[7:0];
  wire [31:0] cnt_word = {16'h0000, rcnt[3], rcnt[2], rcnt[1], rcnt[0]};
  wire [31:0] stat_word = {20'h00000, GATE_ON, wait_rs, latched};
  wire [31:0] rd_mux =
      (rd_addr == pcpc_pkg::A_PAIR) ? {30'h0, pair_join_enable}
    : (rd_addr == pcpc_pkg::A_TRIP) ? {28'h0, low_trip_select}
    : (rd_addr == pcpc_pkg::A_SLEW) ? {28'h0, slow_slew_select}
    : (rd_addr == pcpc_pkg::A_DIAG) ? {29'h0, diag_channel_select}
    : (rd_addr == pcpc_pkg::A_OUT) ? {28'h0, cmd}
    : (rd_addr == pcpc_pkg::A_STAT) ? stat_word
    : (rd_addr == pcpc_pkg::A_CNT) ? cnt_word
    : (rd_addr == pcpc_pkg::A_IRQ_STAT) ? {24'h0, irq_stat}
    : (rd_addr == pcpc_pkg::A_IRQ_EN) ? {24'h0, irq_en} : 32'h0;
  wire rd_take = a_take && !HWRITE;
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) HRDATA <= 32'h0;
    else if (CE && HREADY) HRDATA <= rd_take ? rd_mux : 32'h0;
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  AST_PAIR_JOINT_OFF: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0] && trip_ev[0]) |=> (wait_rs[0] && wait_rs[3]))
    else $error("paired channels 0 and 3 did not switch off together");
  AST_PAIR_TRIP: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[1] && {low_trip_select[1], low_trip_select[2]} == 2'h0)
      |=> TRIP_LEVEL[3:2] == pcpc_pkg::TRIP_PAIR)
    else $error("paired channel 1 not on paired trip level");
  AST_PAIR_LOW_TRIP: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0] && low_trip_select[3])
      |=> TRIP_LEVEL[1:0] == pcpc_pkg::TRIP_PAIR_LOW)
    else $error("channel 0 ignored partner low trip select");
  AST_PAIR_COUNT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0] && upd[0] && !clr_cnt[0] && !clr_cnt[3])
      |=> (rcnt[0] == rcnt[3] && latched[0] == latched[3]))
    else $error("paired restart counters diverged");
  AST_PAIR_SLEW: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[1] && slow_slew_select[2]) |=> SLOW_SLEW[1] && SLOW_SLEW[2])
    else $error("paired slow slew not shared");
  AST_SLOW_SLEW: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && slow_slew_select[2]) |=> SLOW_SLEW[2])
    else $error("slow slew select not applied");
  AST_PAIR_NO_SLC: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0]) |=> !SLC_ENGAGE[0] && !SLC_ENGAGE[3])
    else $error("drop limitation active in paired mode");
  AST_SLC_DIAG: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ($past(CE) && SLC_ENGAGE[1]) |-> $past(diag_channel_select) == 3'h1)
    else $error("drop limitation on undiagnosed channel");
  AST_REV_ON: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && cmd[1] && rev[1] && !wait_rs[1] && !latched[1] && !paired[1]) |=> GATE_ON[1])
    else $error("switch-on refused during reverse flow");
  AST_REV_NO_PROT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && rev[1] && !paired[1] && !wait_rs[1]) |=> !wait_rs[1])
    else $error("protection acted during reverse flow");

  // the checks below, except AST_LATCH_AT_LIMIT, sample registered state one edge after its cause
  AST_JOINT_RESTART: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0] && wait_rs[0] && wait_rs[3])
      |=> wait_rs[0] == wait_rs[3])
    else $error("paired channels 0 and 3 did not restart together");
  AST_TRIP_OFF: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && trip_ev[1])
      |=> (!GATE_ON[1] && wait_rs[1]))
    else $error("fault without reverse flow did not switch channel 1 off");
  AST_LATCH_HOLD: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && latched[0] && !clr_cnt[0])
      |=> (latched[0] && !GATE_ON[0]))
    else $error("latched channel 0 came back on");
  AST_LATCH_AT_LIMIT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (rcnt[0] >= RESTART_LIMIT)
      |-> latched[0])
    else $error("channel 0 at restart limit but not latched");
  AST_CLR_UNLATCH: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && clr_cnt[0])
      |=> (!latched[0] && rcnt[0] == '0))
    else $error("counter clear did not release channel 0");
  AST_REV_KEEP_ON: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && rev[1] && GATE_ON[1] && cmd[1] && !paired[1])
      |=> GATE_ON[1])
    else $error("channel 1 left its on state during reverse flow");
  AST_UNPAIRED_NORM: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !pair_join_enable[1] && !low_trip_select[1])
      |=> TRIP_LEVEL[3:2] == pcpc_pkg::TRIP_NORM)
    else $error("unpaired channel 1 not on normal trip level");
  AST_UNPAIRED_LOW: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !pair_join_enable[1] && low_trip_select[1])
      |=> TRIP_LEVEL[3:2] == pcpc_pkg::TRIP_LOW)
    else $error("unpaired channel 1 not on low trip level");
  AST_UNPAIRED_SLEW: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !pair_join_enable[0] && !slow_slew_select[0])
      |=> !SLOW_SLEW[0])
    else $error("unpaired channel 0 slowed by another channel");
  AST_PAIR_SLEW_ZERO: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && pair_join_enable[0] && slow_slew_select[0])
      |=> SLOW_SLEW[3])
    else $error("channel 3 ignored partner slow slew select");
  AST_SLC_OTHER: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && diag_channel_select != 3'h2)
      |=> !SLC_ENGAGE[2])
    else $error("drop limitation on channel 2 while not diagnosed");
  AST_SLC_ENGAGE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !pair_join_enable[1] && GATE_ON[1] && diag_channel_select == 3'h1 && slc_drop[1])
      |=> SLC_ENGAGE[1])
    else $error("drop limitation not engaged on diagnosed channel 1");
  AST_SLC_GATE_OFF: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && !GATE_ON[3])
      |=> !SLC_ENGAGE[3])
    else $error("drop limitation on switched-off channel 3");
endmodule : pcpc_ctrl

// file: pcpc_load.sv
// load-side model: per-channel current comparators seen by the protection block
// assumes the bench chooses a heavy or light load per channel; no current while off
`timescale 1ns/1ps
module pcpc_load (
  input wire logic [3:0] gate_on,
  input wire logic [3:0] heavy,
  input wire logic [3:0] light,
  output logic [3:0] ovl_norm,
  output logic [3:0] ovl_low,
  output logic [3:0] ovl_pair,
  output logic [3:0] ovl_pair_low,
  output logic [3:0] slc_drop
);
  // a heavy load exceeds every trip level, so any selected level trips
  wire [3:0] over = gate_on & heavy;
  assign ovl_norm = over;
  assign ovl_low = over;
  assign ovl_pair = over;
  assign ovl_pair_low = over;
  // a switched-off channel carries no current, so the drop comparator stays low
  assign slc_drop = gate_on & light;
endmodule : pcpc_load

// file: tb_parallel_channel_protection_ctrl.sv
// self-checking bench for the pair protection control block
// assumes a zero-wait bus slave and the load model beside it
`timescale 1ns/1ps
module tb_parallel_channel_protection_ctrl;
  logic clk, rst_b, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, p;
  logic [3:0] on_n, on_l, on_p, on_pl, temp, rev, slc, gate, slow, eng, heavy, light, lo, sl, seen;
  logic [7:0] trip;
  logic [2:0] d;
  int bad_count = 0;
  int tests_run = 0;
  int seed = 32'h62885C0C;
  pcpc_ctrl #(.RESTART_LIMIT(4'h3)) u_dut (.CLK_SYS(clk), .RST_B(rst_b), .CE(1'b1),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .OVL_NORM(on_n), .OVL_LOW(on_l), .OVL_PAIR(on_p), .OVL_PAIR_LOW(on_pl),
    .OVER_TEMP(temp), .REV_FLOW(rev), .SLC_DROP(slc), .GATE_ON(gate), .SLOW_SLEW(slow),
    .SLC_ENGAGE(eng), .TRIP_LEVEL(trip), .IRQ(irq));
  pcpc_load u_load (.gate_on(gate), .heavy(heavy), .light(light), .ovl_norm(on_n),
    .ovl_low(on_l), .ovl_pair(on_p), .ovl_pair_low(on_pl), .slc_drop(slc));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // address phase held until ready, then data phase held until ready again
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= pcpc_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= v;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  function automatic logic [7:0] exp_trip(input logic [1:0] pp, input logic [3:0] l);
    for (int i = 0; i < 4; i++) begin
      if ((i == 0 || i == 3) ? pp[0] : pp[1]) exp_trip[2*i +: 2] = {1'b1, l[i] | l[3-i]};
      else exp_trip[2*i +: 2] = {1'b0, l[i]};
    end
  endfunction : exp_trip
  function automatic logic [3:0] exp_slew(input logic [1:0] pp, input logic [3:0] l);
    for (int i = 0; i < 4; i++) begin
      exp_slew[i] = l[i] | (((i == 0 || i == 3) ? pp[0] : pp[1]) & l[3-i]);
    end
  endfunction : exp_slew
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {heavy, light, rev, temp} = '0;
    wt(10);
    rst_b <= 1'b1;
    wt(3);
    chk("gate", gate, 4'h0);
    xfer(1'b1, pcpc_pkg::A_IRQ_EN, 32'hFF);
    xfer(1'b1, pcpc_pkg::A_OUT, 32'hF);
    light <= 4'hF;
    for (int k = 0; k < 6; k++) begin
      p = 2'($random(seed));
      lo = 4'($random(seed));
      sl = 4'($random(seed));
      d = 3'($random(seed));
      if (k == 0) begin
        p = 2'h3;
        lo = 4'h8;
        sl = 4'h5;
        d = 3'h3;
      end
      if (k == 1) begin
        p = 2'h1;
        lo = 4'h2;
        d = 3'h1;
      end
      xfer(1'b1, pcpc_pkg::A_CLR_CNT, 32'hF);
      xfer(1'b1, pcpc_pkg::A_PAIR, {30'h0, p});
      xfer(1'b1, pcpc_pkg::A_TRIP, {28'h0, lo});
      xfer(1'b1, pcpc_pkg::A_SLEW, {28'h0, sl});
      xfer(1'b1, pcpc_pkg::A_DIAG, {29'h0, d});
      wt(4);
      chk("trip", trip, exp_trip(p, lo));
      chk("slew", slow, exp_slew(p, sl));
      chk("slc", eng, (d < 4 ? 4'h1 << d : 4'h0) & ~{p[0], p[1], p[1], p[0]});
      xfer(1'b0, pcpc_pkg::A_PAIR, 32'h0);
      chk("pair read", q, {30'h0, p});
    end
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test configuration done");
    light <= 4'h0;
    xfer(1'b1, pcpc_pkg::A_PAIR, 32'h1);
    xfer(1'b1, pcpc_pkg::A_IRQ_CLR, 32'hFF);
    heavy <= 4'h1;
    wt(6);
    chk("paired trip", gate, 4'h6);
    chk("irq", irq, 1'b1);
    heavy <= 4'h0;
    xfer(1'b1, pcpc_pkg::A_IRQ_EN, 32'h0);
    wt(1);
    chk("irq masked", irq, 1'b0);
    xfer(1'b1, pcpc_pkg::A_IRQ_EN, 32'hFF);
    xfer(1'b1, pcpc_pkg::A_IRQ_CLR, 32'hFF);
    wt(1);
    chk("irq cleared", irq, 1'b0);
    wt(420);
    chk("joint restart", gate, 4'hF);
    heavy <= 4'h1;
    wt(2200);
    seen = 4'h0;
    repeat (450) begin
      @(posedge clk);
      seen |= gate;
    end
    chk("latched", seen, 4'h6);
    xfer(1'b0, pcpc_pkg::A_CNT, 32'h0);
    chk("count ch0", q[3:0], 4'h3);
    chk("count ch3", q[15:12], 4'h3);
    xfer(1'b0, pcpc_pkg::A_STAT, 32'h0);
    chk("status", q, 32'h609);
    xfer(1'b0, pcpc_pkg::A_IRQ_STAT, 32'h0);
    chk("irq status", q, 32'h91);
    chk("resp", hresp, 1'b0);
    heavy <= 4'h0;
    xfer(1'b1, pcpc_pkg::A_CLR_CNT, 32'hF);
    wt(420);
    chk("unlatched", gate, 4'hF);
    $display("test pairing done");
    xfer(1'b1, pcpc_pkg::A_PAIR, 32'h0);
    xfer(1'b1, pcpc_pkg::A_OUT, 32'h0);
    rev <= 4'h2;
    wt(6);
    chk("reverse off", gate, 4'h0);
    xfer(1'b1, pcpc_pkg::A_OUT, 32'h2);
    wt(4);
    chk("reverse on", gate, 4'h2);
    heavy <= 4'h2;
    temp <= 4'h2;
    wt(8);
    chk("reverse kept", gate, 4'h2);
    rev <= 4'h0;
    wt(8);
    chk("protect back", gate, 4'h0);
    $display("test reverse flow done");
    conclude();
  end
endmodule : tb_parallel_channel_protection_ctrl
